// ===== pkg/sgd_pkg.sv
// shared constants and carrier types for the step generator and diagnostics block
package sgd_pkg;
  localparam int VEL_W = 24;
  localparam int PHASE_W = 23;
  localparam int MICROSTEP_COUNTER_W = 10;
  localparam int STEP_PERIOD_COUNT_W = 20;
  localparam logic [STEP_PERIOD_COUNT_W-1:0] STEP_PERIOD_COUNT_MAX = 20'hfffff;
  localparam logic [MICROSTEP_COUNTER_W-1:0] MICROSTEP_COUNTER_ZERO = 10'h000;
  localparam logic [MICROSTEP_COUNTER_W-1:0] MICROSTEP_COUNTER_ONE = 10'h001;
  localparam int SHORT_RETRIES = 3;
  localparam logic [1:0] RETRY_LIMIT = 2'(SHORT_RETRIES);
  // thermal setting codes: 0 143/120, 1 150/120, 2 150/143, 3 157/143
  localparam logic [1:0] OT_143_PW120 = 2'h0;
  localparam logic [1:0] OT_150_PW120 = 2'h1;
  localparam logic [1:0] OT_150_PW143 = 2'h2;
  localparam logic [1:0] OT_157_PW143 = 2'h3;
  localparam logic [1:0] OT_DEFAULT = OT_143_PW120;

  typedef struct packed {
    logic ge_120;
    logic ge_143;
    logic ge_150;
    logic ge_157;
  } sgd_temp_s;

  typedef struct packed {
    logic gnd_a;
    logic gnd_b;
    logic sup_a;
    logic sup_b;
  } sgd_short_s;

  typedef struct packed {
    logic overtemp_shutdown_flag;
    logic overtemp_prewarn;
    logic short_ground_coil_a;
    logic short_ground_coil_b;
    logic short_supply_coil_a;
    logic short_supply_coil_b;
    logic open_load_a;
    logic open_load_b;
  } sgd_status_s;
endpackage : sgd_pkg

// ===== logic/sgd_short_guard.sv
// short detector for one bridge: confirm by retries, latch flags until disable
`timescale 1ns/1ns
module sgd_short_guard (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // control
  input wire logic enable,
  input wire logic check,
  // synchronised detector levels
  input wire logic det_gnd,
  input wire logic det_sup,
  // results
  output logic flag_gnd,
  output logic flag_sup,
  output logic bridge_off
);
  import sgd_pkg::*;
  logic [1:0] retries;
  logic hit;
  assign hit = det_gnd | det_sup;
  // one event per check strobe; an event while flagged is ignored
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      retries <= 2'h0;
    end else if (!enable) begin
      retries <= 2'h0;
    end else if (check && !bridge_off) begin
      if (!hit) begin
        retries <= 2'h0;
      end else if (retries != RETRY_LIMIT) begin
        retries <= retries + 2'h1;
      end
    end
  end
  // confirmed after three retries all still shorted
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      flag_gnd <= 1'b0;
      flag_sup <= 1'b0;
    end else if (!enable) begin
      flag_gnd <= 1'b0;
      flag_sup <= 1'b0;
    end else if (check && !bridge_off && hit && retries == RETRY_LIMIT) begin
      flag_gnd <= det_gnd;
      flag_sup <= det_sup;
    end
  end
  assign bridge_off = flag_gnd | flag_sup;
endmodule : sgd_short_guard

// ===== logic/sgd_step_fault_output.sv
// internal step pulse generator with thermal, short and open-load diagnostics
// Summary of operation
// - position advances at velocity times fclk/2/2^23
// - velocity is signed; sign sets direction
// - step period counted in clocks between microsteps
// - index toggles per step when selected
// - microstep counter wraps 1023 to 0
// - four shutdown settings, default 143/120
// - 157 setting only from serial interface
// - overtemp holds driver off until below prewarn
// - short confirmed after three retries
// - confirmed short switches off its bridge, flags
// - open load set when current unreachable
// - open load is informational only
// - fault output when driver cannot operate
// - index marks counter zero by default
// - index zero is coil A positive crossing
`timescale 1ns/1ns
module sgd_step_fault_output (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // configuration from serial interface or otp
  input wire logic DRV_ENABLE,
  input wire logic signed [sgd_pkg::VEL_W-1:0] INTERNAL_VELOCITY,
  input wire logic INDEX_STEP_PULSE_SELECT,
  input wire logic [1:0] OT_SELECT,
  input wire logic OT_FROM_SERIAL,
  // analog comparator levels (asynchronous)
  input wire sgd_pkg::sgd_temp_s TEMP_LEVELS,
  input wire sgd_pkg::sgd_short_s SHORT_DETECT,
  input wire logic SHORT_CHECK,
  input wire logic CURRENT_REACHED_A,
  input wire logic CURRENT_REACHED_B,
  input wire logic CURRENT_SAMPLE,
  // motion results
  output logic [sgd_pkg::MICROSTEP_COUNTER_W-1:0] MICROSTEP_COUNTER,
  output logic [sgd_pkg::STEP_PERIOD_COUNT_W-1:0] STEP_PERIOD_COUNT,
  output logic MICROSTEP_PULSE,
  output logic STEP_DIR,
  // bridge control
  output logic BRIDGE_A_ON,
  output logic BRIDGE_B_ON,
  // status
  output sgd_pkg::sgd_status_s DRIVER_STATUS_WORD,
  output logic FAULT_OUTPUT,
  output logic INDEX_OUT
);
  import sgd_pkg::*;

  // two-flop synchronisers for all analog levels except CURRENT_SAMPLE
  localparam int SYN_W = 11;
  logic [SYN_W-1:0] syn_raw, syn_1, syn_2;
  assign syn_raw = {TEMP_LEVELS, SHORT_DETECT, CURRENT_REACHED_A, CURRENT_REACHED_B, SHORT_CHECK};
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      syn_1 <= '0;
      syn_2 <= '0;
    end else begin
      syn_1 <= syn_raw;
      syn_2 <= syn_1;
    end
  end
  sgd_temp_s temp;
  sgd_short_s shrt;
  logic reach_a, reach_b, check_lvl, check_d, check_pulse;
  assign {temp, shrt, reach_a, reach_b, check_lvl} = syn_2;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      check_d <= 1'b0;
    end else begin
      check_d <= check_lvl;
    end
  end
  assign check_pulse = check_lvl & ~check_d;

  // velocity accumulator: half clock rate means adding |v| every second cycle
  logic half_en;
  logic [PHASE_W-1:0] phase;
  logic [PHASE_W:0] next_phase;
  logic [VEL_W-1:0] vel_mag;
  logic vel_neg, step_now;
  assign vel_neg = INTERNAL_VELOCITY[VEL_W-1];
  assign vel_mag = vel_neg ? VEL_W'(-INTERNAL_VELOCITY) : VEL_W'(INTERNAL_VELOCITY);
  // velocity applied as written, no ramp limiting
  assign next_phase = {1'b0, phase} + (PHASE_W+1)'(vel_mag);
  assign step_now = half_en & next_phase[PHASE_W];
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      half_en <= 1'b0;
    end else begin
      half_en <= ~half_en;
    end
  end
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      phase <= '0;
    end else if (!DRV_ENABLE) begin
      phase <= '0;
    end else if (half_en) begin
      phase <= next_phase[PHASE_W-1:0];
    end
  end

  // microstep counter; direction from velocity sign
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      MICROSTEP_COUNTER <= MICROSTEP_COUNTER_ZERO;
      STEP_DIR <= 1'b0;
      MICROSTEP_PULSE <= 1'b0;
    end else begin
      MICROSTEP_PULSE <= step_now;
      if (step_now) begin
        STEP_DIR <= vel_neg;
        // natural 10-bit wrap gives 1023 to 0 going up
        MICROSTEP_COUNTER <= vel_neg ? MICROSTEP_COUNTER - MICROSTEP_COUNTER_ONE : MICROSTEP_COUNTER + MICROSTEP_COUNTER_ONE;
      end
    end
  end

  // step period: clocks between microsteps, saturating at the standstill value
  logic [STEP_PERIOD_COUNT_W-1:0] period_cnt;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      period_cnt <= '0;
      STEP_PERIOD_COUNT <= STEP_PERIOD_COUNT_MAX;
    end else if (step_now) begin
      // a step after a long standstill must not wrap to zero
      STEP_PERIOD_COUNT <= (period_cnt == STEP_PERIOD_COUNT_MAX) ? STEP_PERIOD_COUNT_MAX : period_cnt + STEP_PERIOD_COUNT_W'(1);
      period_cnt <= '0;
    end else if (period_cnt != STEP_PERIOD_COUNT_MAX) begin
      period_cnt <= period_cnt + STEP_PERIOD_COUNT_W'(1);
      if (period_cnt + STEP_PERIOD_COUNT_W'(1) == STEP_PERIOD_COUNT_MAX) begin
        STEP_PERIOD_COUNT <= STEP_PERIOD_COUNT_MAX;
      end
    end
  end

  // thermal thresholds
  logic [1:0] ot_eff;
  logic shut_hit, warn_hit;
  // otp cannot reach the highest setting; falls back to the next lower one
  assign ot_eff = (OT_SELECT == OT_157_PW143 && !OT_FROM_SERIAL) ? OT_150_PW143 : OT_SELECT;
  always_comb begin
    case (ot_eff)
      OT_143_PW120: begin
        shut_hit = temp.ge_143;
        warn_hit = temp.ge_120;
      end
      OT_150_PW120: begin
        shut_hit = temp.ge_150;
        warn_hit = temp.ge_120;
      end
      OT_150_PW143: begin
        shut_hit = temp.ge_150;
        warn_hit = temp.ge_143;
      end
      default: begin
        shut_hit = temp.ge_157;
        warn_hit = temp.ge_143;
      end
    endcase
  end
  logic ot_flag;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ot_flag <= 1'b0;
    end else if (shut_hit) begin
      ot_flag <= 1'b1;
    end else if (!warn_hit) begin
      ot_flag <= 1'b0;
    end
  end

  // short protection per bridge
  logic gnd_a, sup_a, off_a, gnd_b, sup_b, off_b;
  sgd_short_guard u_guard_a (
    .REF_CLK(REF_CLK),
    .RESETN(RESETN),
    .enable(DRV_ENABLE),
    .check(check_pulse),
    .det_gnd(shrt.gnd_a),
    .det_sup(shrt.sup_a),
    .flag_gnd(gnd_a),
    .flag_sup(sup_a),
    .bridge_off(off_a)
  );
  sgd_short_guard u_guard_b (
    .REF_CLK(REF_CLK),
    .RESETN(RESETN),
    .enable(DRV_ENABLE),
    .check(check_pulse),
    .det_gnd(shrt.gnd_b),
    .det_sup(shrt.sup_b),
    .flag_gnd(gnd_b),
    .flag_sup(sup_b),
    .bridge_off(off_b)
  );

  // open load: sampled on each current check, no effect on bridges
  logic ol_a, ol_b, sample_d;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sample_d <= 1'b0;
    end else begin
      sample_d <= CURRENT_SAMPLE;
    end
  end
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ol_a <= 1'b0;
      ol_b <= 1'b0;
    end else if (sample_d) begin
      ol_a <= ~reach_a;
      ol_b <= ~reach_b;
    end
  end

  // bridge enables and status outputs, registered
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      BRIDGE_A_ON <= 1'b0;
      BRIDGE_B_ON <= 1'b0;
      FAULT_OUTPUT <= 1'b0;
      DRIVER_STATUS_WORD <= '0;
    end else begin
      // open load deliberately absent from both terms
      BRIDGE_A_ON <= DRV_ENABLE & ~ot_flag & ~off_a;
      BRIDGE_B_ON <= DRV_ENABLE & ~ot_flag & ~off_b;
      FAULT_OUTPUT <= ot_flag | off_a | off_b;
      DRIVER_STATUS_WORD <= '{ot_flag, warn_hit, gnd_a, gnd_b, sup_a, sup_b, ol_a, ol_b};
    end
  end

  // index: counter zero (coil a positive crossing) or step toggle
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      INDEX_OUT <= 1'b0;
    end else if (INDEX_STEP_PULSE_SELECT) begin
      if (step_now) begin
        INDEX_OUT <= ~INDEX_OUT;
      end
    end else begin
      INDEX_OUT <= (MICROSTEP_COUNTER == MICROSTEP_COUNTER_ZERO);
    end
  end
endmodule : sgd_step_fault_output

// ===== verification/sgd_step_fault_output_assertions.sv
// port-level checks for the step generator and diagnostics block
`timescale 1ns/1ns
module sgd_step_fault_output_assertions (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // watched ports
  input wire logic DRV_ENABLE,
  input wire logic INDEX_STEP_PULSE_SELECT,
  input wire logic [sgd_pkg::MICROSTEP_COUNTER_W-1:0] MICROSTEP_COUNTER,
  input wire logic MICROSTEP_PULSE,
  input wire logic STEP_DIR,
  input wire logic BRIDGE_A_ON,
  input wire logic BRIDGE_B_ON,
  input wire sgd_pkg::sgd_status_s DRIVER_STATUS_WORD,
  input wire logic FAULT_OUTPUT,
  input wire logic INDEX_OUT
);
  import sgd_pkg::*;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);
  // direction must be settled one cycle before a step counts
  sequence s_step_up;
    MICROSTEP_PULSE && !STEP_DIR && !$past(STEP_DIR);
  endsequence
  sequence s_step_dn;
    MICROSTEP_PULSE && STEP_DIR && $past(STEP_DIR);
  endsequence
  a_count_up: assert property (s_step_up |-> MICROSTEP_COUNTER == $past(MICROSTEP_COUNTER) + MICROSTEP_COUNTER_ONE)
    else $error("counter did not advance by one");
  a_count_down: assert property (s_step_dn |-> MICROSTEP_COUNTER == $past(MICROSTEP_COUNTER) - MICROSTEP_COUNTER_ONE)
    else $error("counter did not go back by one");
  a_count_hold: assert property (!MICROSTEP_PULSE |-> $stable(MICROSTEP_COUNTER))
    else $error("counter moved without a step");
  a_index_step: assert property (INDEX_STEP_PULSE_SELECT && $past(INDEX_STEP_PULSE_SELECT)
    |-> (INDEX_OUT != $past(INDEX_OUT)) == MICROSTEP_PULSE)
    else $error("index toggle not tied to step");
  // reset values still stand at the first edge after release
  a_index_zero: assert property ($past(RESETN) && !INDEX_STEP_PULSE_SELECT
    && !$past(INDEX_STEP_PULSE_SELECT) |-> INDEX_OUT == ($past(MICROSTEP_COUNTER) == MICROSTEP_COUNTER_ZERO))
    else $error("index does not mark counter zero");
  // bridges and status word are registered from the same internal flags
  a_bridge_a: assert property ($past(RESETN) |-> BRIDGE_A_ON == ($past(DRV_ENABLE)
    && !DRIVER_STATUS_WORD.overtemp_shutdown_flag && !DRIVER_STATUS_WORD.short_ground_coil_a
    && !DRIVER_STATUS_WORD.short_supply_coil_a))
    else $error("bridge a state wrong");
  a_bridge_b: assert property ($past(RESETN) |-> BRIDGE_B_ON == ($past(DRV_ENABLE)
    && !DRIVER_STATUS_WORD.overtemp_shutdown_flag && !DRIVER_STATUS_WORD.short_ground_coil_b
    && !DRIVER_STATUS_WORD.short_supply_coil_b))
    else $error("bridge b state wrong");
  a_fault_out: assert property (FAULT_OUTPUT == (DRIVER_STATUS_WORD.overtemp_shutdown_flag
    || (DRIVER_STATUS_WORD[5:2] != 4'h0)))
    else $error("fault output does not follow shutdown");
  // flags clear one edge after disable, the status copy one edge later
  a_short_clear: assert property (!DRV_ENABLE |-> ##2 DRIVER_STATUS_WORD[5:2] == 4'h0)
    else $error("short flags survived disable");
endmodule : sgd_step_fault_output_assertions

bind sgd_step_fault_output sgd_step_fault_output_assertions chk_u (
  .REF_CLK(REF_CLK),
  .RESETN(RESETN),
  .DRV_ENABLE(DRV_ENABLE),
  .INDEX_STEP_PULSE_SELECT(INDEX_STEP_PULSE_SELECT),
  .MICROSTEP_COUNTER(MICROSTEP_COUNTER),
  .MICROSTEP_PULSE(MICROSTEP_PULSE),
  .STEP_DIR(STEP_DIR),
  .BRIDGE_A_ON(BRIDGE_A_ON),
  .BRIDGE_B_ON(BRIDGE_B_ON),
  .DRIVER_STATUS_WORD(DRIVER_STATUS_WORD),
  .FAULT_OUTPUT(FAULT_OUTPUT),
  .INDEX_OUT(INDEX_OUT)
);

// ===== verification/sgd_host_model.sv
// host model: holds the settings a serial host writes into the driver
`timescale 1ns/1ns
module sgd_host_model (
  // clock
  input wire logic REF_CLK,
  // settings
  output logic DRV_ENABLE,
  output logic signed [sgd_pkg::VEL_W-1:0] INTERNAL_VELOCITY,
  output logic INDEX_STEP_PULSE_SELECT,
  output logic [1:0] OT_SELECT,
  output logic OT_FROM_SERIAL
);
  import sgd_pkg::*;
  localparam logic signed [VEL_W-1:0] RAMP_STEP = 24'h100000;
  initial begin
    DRV_ENABLE = 1'b1;
    INTERNAL_VELOCITY = 24'h000000;
    INDEX_STEP_PULSE_SELECT = 1'b0;
    OT_SELECT = OT_DEFAULT;
    OT_FROM_SERIAL = 1'b0;
  end
  // the driver has no ramp, so the host walks in small increments
  task automatic ramp_to(input logic signed [VEL_W-1:0] target);
    while (INTERNAL_VELOCITY != target) begin
      @(posedge REF_CLK);
      #1;
      if (target > INTERNAL_VELOCITY + RAMP_STEP) INTERNAL_VELOCITY += RAMP_STEP;
      else if (target < INTERNAL_VELOCITY - RAMP_STEP) INTERNAL_VELOCITY -= RAMP_STEP;
      else INTERNAL_VELOCITY = target;
    end
  endtask : ramp_to
  task automatic configure(input logic sel, input logic [1:0] code, input logic serial);
    @(posedge REF_CLK);
    #1;
    INDEX_STEP_PULSE_SELECT = sel;
    OT_SELECT = code;
    OT_FROM_SERIAL = serial;
  endtask : configure
  task automatic restart();
    @(posedge REF_CLK);
    #1;
    DRV_ENABLE = 1'b0;
    @(posedge REF_CLK);
    #1;
    DRV_ENABLE = 1'b1;
  endtask : restart
endmodule : sgd_host_model

// ===== verification/sgd_step_fault_output_test.sv
// self-checking bench for the step generator and diagnostics block
`timescale 1ns/1ns
module sgd_step_fault_output_test;
  import sgd_pkg::*;
  logic REF_CLK = 1'b0;
  logic RESETN = 1'b0;
  wire DRV_ENABLE, INDEX_STEP_PULSE_SELECT, OT_FROM_SERIAL;
  wire [1:0] OT_SELECT;
  wire signed [VEL_W-1:0] INTERNAL_VELOCITY;
  sgd_temp_s TEMP_LEVELS = 4'h0;
  sgd_short_s SHORT_DETECT = 4'h0;
  logic SHORT_CHECK = 1'b0;
  logic CURRENT_REACHED_A = 1'b1;
  logic CURRENT_REACHED_B = 1'b1;
  logic CURRENT_SAMPLE = 1'b0;
  logic [MICROSTEP_COUNTER_W-1:0] MICROSTEP_COUNTER;
  logic [STEP_PERIOD_COUNT_W-1:0] STEP_PERIOD_COUNT;
  logic MICROSTEP_PULSE, STEP_DIR, BRIDGE_A_ON, BRIDGE_B_ON, FAULT_OUTPUT, INDEX_OUT;
  sgd_status_s DRIVER_STATUS_WORD;
  int n_errors = 0;
  int n_compared = 0;
  always #2 REF_CLK = ~REF_CLK;
  sgd_host_model host_u (.*);
  sgd_step_fault_output dut_u (.*);
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask : tick
  task automatic heat(input int t);
    TEMP_LEVELS = {t >= 1, t >= 2, t >= 3, t >= 4};
    tick(6);
  endtask : heat
  task automatic short_check();
    SHORT_CHECK = 1'b1;
    tick(2);
    SHORT_CHECK = 1'b0;
    tick(6);
  endtask : short_check
  task automatic test_steps();
    int n;
    tick(2);
    check("index at zero", 1, INDEX_OUT);
    check("period idle", STEP_PERIOD_COUNT_MAX, STEP_PERIOD_COUNT);
    host_u.configure(1'b1, OT_DEFAULT, 1'b0);
    host_u.ramp_to(24'h400000);
    for (int k = 0; k < 64 && MICROSTEP_PULSE !== 1'b1; k++) tick(1);
    n = 0;
    // long enough to pass the counter wrap
    repeat (4400) begin
      tick(1);
      n += (MICROSTEP_PULSE === 1'b1);
    end
    check("pulses", 1100, n);
    check("period", 4, STEP_PERIOD_COUNT);
    check("dir up", 0, STEP_DIR);
    host_u.ramp_to(-24'sh400000);
    tick(40);
    check("dir down", 1, STEP_DIR);
    host_u.ramp_to(24'h000000);
    $display("test_steps done");
  endtask : test_steps
  task automatic test_thermal();
    for (int c = 0; c < 5; c++) begin
      int s = (c == 0) ? 2 : (c == 3) ? 4 : 3;
      int p = (c >= 2) ? 2 : 1;
      host_u.configure(1'b0, 2'(c > 3 ? 3 : c), c == 3);
      heat(s - 1);
      check("ot below", 2'b01, {DRIVER_STATUS_WORD.overtemp_shutdown_flag, DRIVER_STATUS_WORD.overtemp_prewarn});
      heat(s);
      check("ot at", 3'h4, {DRIVER_STATUS_WORD.overtemp_shutdown_flag, BRIDGE_A_ON, BRIDGE_B_ON});
      check("fault ot", 1, FAULT_OUTPUT);
      heat(p);
      check("ot held", 3'h4, {DRIVER_STATUS_WORD.overtemp_shutdown_flag, BRIDGE_A_ON, BRIDGE_B_ON});
      heat(p - 1);
      check("ot cleared", 0, {DRIVER_STATUS_WORD.overtemp_shutdown_flag, DRIVER_STATUS_WORD.overtemp_prewarn});
      heat(0);
    end
    $display("test_thermal done");
  endtask : test_thermal
  task automatic test_shorts();
    SHORT_DETECT = 4'h8;
    repeat (2) short_check();
    SHORT_DETECT = 4'h0;
    short_check();
    SHORT_DETECT = 4'h8;
    repeat (3) short_check();
    check("retry reset", 0, DRIVER_STATUS_WORD[5:2]);
    host_u.restart();
    for (int i = 0; i < 4; i++) begin
      SHORT_DETECT = 4'h8 >> i;
      repeat (3) short_check();
      check("short early", 0, DRIVER_STATUS_WORD[5:2]);
      short_check();
      check("short flag", 4'h8 >> i, DRIVER_STATUS_WORD[5:2]);
      check("bridges", i[0] ? 2'b10 : 2'b01, {BRIDGE_A_ON, BRIDGE_B_ON});
      check("fault short", 1, FAULT_OUTPUT);
      SHORT_DETECT = 4'h0;
      host_u.restart();
      tick(4);
      check("restart", 6'h03, {DRIVER_STATUS_WORD[5:2], BRIDGE_A_ON, BRIDGE_B_ON});
    end
    $display("test_shorts done");
  endtask : test_shorts
  task automatic test_open_load();
    for (int r = 0; r < 2; r++) begin
      CURRENT_REACHED_A = r[0];
      CURRENT_REACHED_B = !r[0];
      tick(4);
      CURRENT_SAMPLE = 1'b1;
      tick(1);
      CURRENT_SAMPLE = 1'b0;
      tick(4);
      check("open load", {!r[0], r[0]}, DRIVER_STATUS_WORD[1:0]);
      check("bridges ol", 3'h6, {BRIDGE_A_ON, BRIDGE_B_ON, FAULT_OUTPUT});
    end
    $display("test_open_load done");
  endtask : test_open_load
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    tick(10);
    RESETN = 1'b1;
    test_steps();
    test_thermal();
    test_shorts();
    test_open_load();
    tally_and_finish();
  end
  // about five times the expected run
  initial begin
    #100000;
    n_errors++;
    $display("[FAIL] watchdog expected done seen timeout");
    tally_and_finish();
  end
endmodule : sgd_step_fault_output_test
